// >>> rtl/tws_status.sv
// Status flag logic of a two-wire bus controller with an Avalon-MM slave.
// Assumes bus event pulses come from the shifter logic on the same clock.
`timescale 1ns/1ps
`include "tws_consts.svh"
module tws_status (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] avs_address, // Byte address of the word.
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic tx_start, // Master transmission begins.
   input wire logic bit_done, // One data bit shifted.
   input wire logic ack_end, // End of slave acknowledge period.
   input wire logic ack_nack, // Sampled acknowledge level, high for NACK.
   input wire logic collision, // Bus collision during master operation.
   input wire logic addr_byte_rx, // Received address byte, data on rx_byte.
   input wire logic addr_match, // Own address matched in slave mode.
   input wire logic ten_second_match, // Second byte of ten-bit address matched.
   input wire logic slave_data_rx, // Slave data byte received.
   input wire logic rx_done, // Shift register ready to move to buffer.
   input wire logic [7:0] rx_byte,
   input wire logic start_seen,
   input wire logic stop_seen,
   input wire logic read_dir,
   input wire logic tx_taken, // Shifter took the transmit byte.
   output logic [7:0] tx_data, // Byte waiting in the transmit register.
   output logic module_on
);
   logic rd_q, rd_d; // Read answer pending.
   logic [31:0] rdata_q, rdata_d;
   logic on_q, on_d;
   logic nack_q, nack_d;
   tws_pkg::tws_tx_state_t st_q, st_d;
   logic [2:0] cnt_q, cnt_d;
   logic gc_q, gc_d, ten_q, ten_d, da_q, da_d;
   logic p_q, p_d, s_q, s_d, rw_q, rw_d;
   logic rbf_q, rbf_d, tbf_q, tbf_d;
   logic [7:0] rxb_q, rxb_d, txb_q, txb_d;
   logic wr_stat, wr_ctl, wr_tx, rd_rx, busy;
   logic wcol_set, rov_set, bcol_clr;
   logic bcol_q, wcol_q, rov_q;
   logic master_tx_active, nack_seen;
   logic [31:0] status;

   // Writes complete at once; reads wait one cycle for registered data.
   assign avs_waitrequest = avs_read & ~rd_q;
   assign wr_stat = avs_write && avs_address == `TWS_OFF_STATUS;
   assign wr_ctl = avs_write && avs_address == `TWS_OFF_CONTROL;
   assign wr_tx = avs_write && avs_address == `TWS_OFF_TXDATA;
   assign rd_rx = avs_read && rd_q && avs_address == `TWS_OFF_RXDATA;
   // Busy means a transfer is running or a byte is still waiting to go.
   assign busy = master_tx_active | tbf_q;
   assign wcol_set = wr_tx & busy;
   assign rov_set = rx_done & rbf_q & ~rd_rx;
   // Collision clears only on the rising edge of the enable bit.
   assign bcol_clr = wr_ctl & avs_writedata[`TWS_BIT_ENABLE] & ~on_q;
   assign master_tx_active = st_q != tws_pkg::TWS_TX_IDLE;
   assign nack_seen = nack_q;
   assign tx_data = txb_q;
   assign module_on = on_q;
   assign avs_readdata = rdata_q;

   // Assemble the status word; unused positions are constant zero.
   always_comb begin
      status = 32'h00000000;
      status[`TWS_BIT_NACK] = nack_seen;
      status[`TWS_BIT_TXACT] = master_tx_active;
      status[`TWS_BIT_BCOL] = bcol_q;
      status[`TWS_BIT_GCALL] = gc_q;
      status[`TWS_BIT_TEN] = ten_q;
      status[`TWS_BIT_WCOL] = wcol_q;
      status[`TWS_BIT_ROV] = rov_q;
      status[`TWS_BIT_DA] = da_q;
      status[`TWS_BIT_STOP] = p_q;
      status[`TWS_BIT_START] = s_q;
      status[`TWS_BIT_RDIR] = rw_q;
      status[`TWS_BIT_RBF] = rbf_q;
      status[`TWS_BIT_TBF] = tbf_q;
   end

   // Sticky flags that software or re-enable clears.
   tws_sticky u_bcol (.clk(clk), .rst_n(rst_n), .set_i(collision & on_q), .clr_i(bcol_clr), .flag_q(bcol_q));
   tws_sticky u_wcol (.clk(clk), .rst_n(rst_n), .set_i(wcol_set),
      .clr_i(wr_stat & ~avs_writedata[`TWS_BIT_WCOL]), .flag_q(wcol_q));
   tws_sticky u_rov (.clk(clk), .rst_n(rst_n), .set_i(rov_set),
      .clr_i(wr_stat & ~avs_writedata[`TWS_BIT_ROV]), .flag_q(rov_q));

   // Bus answer and control register next values.
   always_comb begin
      rd_d = avs_read & ~rd_q;
      rdata_d = 32'h00000000;
      // Unmapped addresses read as zero and ignore writes.
      if (avs_read & ~rd_q) begin
         case (avs_address)
            `TWS_OFF_STATUS: rdata_d = status & `TWS_STATUS_MASK;
            `TWS_OFF_CONTROL: rdata_d = {31'h00000000, on_q};
            `TWS_OFF_TXDATA: rdata_d = {24'h000000, txb_q};
            `TWS_OFF_RXDATA: rdata_d = {24'h000000, rxb_q};
            default: rdata_d = 32'h00000000;
         endcase
      end
      on_d = wr_ctl ? avs_writedata[`TWS_BIT_ENABLE] : on_q;
   end

   // Transmit progress: eight bits then the acknowledge.
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      nack_d = nack_q;
      case (st_q)
         tws_pkg::TWS_TX_IDLE: begin
            if (tx_start) begin
               st_d = tws_pkg::TWS_TX_BITS;
               cnt_d = 3'h0;
            end
         end
         tws_pkg::TWS_TX_BITS: begin
            if (bit_done) begin
               cnt_d = 3'(cnt_q + 3'h1);
               if (cnt_q == 3'h7) begin
                  st_d = tws_pkg::TWS_TX_ACK;
               end
            end
         end
         tws_pkg::TWS_TX_ACK: begin
            if (ack_end) begin
               st_d = tws_pkg::TWS_TX_IDLE;
               nack_d = ack_nack;
            end
         end
         default: st_d = tws_pkg::TWS_TX_IDLE;
      endcase
      if (!on_q) begin
         st_d = tws_pkg::TWS_TX_IDLE;
      end
   end

   // Slave address flags, bus condition flags and the two buffers.
   always_comb begin
      gc_d = gc_q;
      ten_d = ten_q;
      da_d = da_q;
      if (stop_seen) begin
         gc_d = 1'b0;
         ten_d = 1'b0;
      end
      if (addr_byte_rx && rx_byte == `TWS_GCALL_ADDR) begin
         gc_d = 1'b1;
      end
      if (ten_second_match) begin
         ten_d = 1'b1;
      end
      // An address match outranks a data byte in the same cycle.
      if (slave_data_rx) begin
         da_d = 1'b1;
      end
      if (addr_match) begin
         da_d = 1'b0;
      end
      p_d = stop_seen ? 1'b1 : (start_seen ? 1'b0 : p_q);
      s_d = start_seen ? 1'b1 : (stop_seen ? 1'b0 : s_q);
      rw_d = read_dir;
      // An overflowing byte is lost; the buffer keeps the unread one.
      rbf_d = rbf_q;
      rxb_d = rxb_q;
      if (rd_rx) begin
         rbf_d = 1'b0;
      end
      if (rx_done && !rov_set) begin
         rbf_d = 1'b1;
         rxb_d = rx_byte;
      end
      tbf_d = tbf_q;
      txb_d = txb_q;
      if (tx_taken) begin
         tbf_d = 1'b0;
      end
      if (wr_tx && !busy) begin
         tbf_d = 1'b1;
         txb_d = avs_writedata[7:0];
      end
   end

   // Register all state but the sticky flags; synchronous reset clears everything.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_q <= 1'b0;
         rdata_q <= 32'h00000000;
         on_q <= 1'b0;
         st_q <= tws_pkg::TWS_TX_IDLE;
         cnt_q <= 3'h0;
         nack_q <= 1'b0;
         gc_q <= 1'b0;
         ten_q <= 1'b0;
         da_q <= 1'b0;
         p_q <= 1'b0;
         s_q <= 1'b0;
         rw_q <= 1'b0;
         rbf_q <= 1'b0;
         rxb_q <= 8'h00;
         tbf_q <= 1'b0;
         txb_q <= 8'h00;
      end else begin
         rd_q <= rd_d;
         rdata_q <= rdata_d;
         on_q <= on_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         nack_q <= nack_d;
         gc_q <= gc_d;
         ten_q <= ten_d;
         da_q <= da_d;
         p_q <= p_d;
         s_q <= s_d;
         rw_q <= rw_d;
         rbf_q <= rbf_d;
         rxb_q <= rxb_d;
         tbf_q <= tbf_d;
         txb_q <= txb_d;
      end
   end

   // Checks on the flag behaviour.
   property p_nack_update;
      @(posedge clk) disable iff (!rst_n) (st_q == tws_pkg::TWS_TX_ACK && ack_end && on_q) |=>
         nack_q == $past(ack_nack);
   endproperty
   a_nack_update: assert property (p_nack_update) else $error("nack flag not updated at ack end");
   property p_tx_start;
      @(posedge clk) disable iff (!rst_n) (st_q == tws_pkg::TWS_TX_IDLE && tx_start && on_q) |=> master_tx_active;
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("transmit active not raised");
   property p_tx_end;
      @(posedge clk) disable iff (!rst_n) (st_q == tws_pkg::TWS_TX_ACK && ack_end) |=> !master_tx_active;
   endproperty
   a_tx_end: assert property (p_tx_end) else $error("transmit active not cleared");
   property p_bcol_hold;
      @(posedge clk) disable iff (!rst_n) (bcol_q && !bcol_clr) |=> bcol_q;
   endproperty
   a_bcol_hold: assert property (p_bcol_hold) else $error("collision flag dropped");
   property p_gc_stop;
      @(posedge clk) disable iff (!rst_n) (stop_seen && !addr_byte_rx) |=> !gc_q;
   endproperty
   a_gc_stop: assert property (p_gc_stop) else $error("general call not cleared on stop");
   property p_ten_set;
      @(posedge clk) disable iff (!rst_n) ten_second_match |=> ten_q;
   endproperty
   a_ten_set: assert property (p_ten_set) else $error("ten bit flag not set");
   property p_wcol;
      @(posedge clk) disable iff (!rst_n) wr_tx && busy |=> wcol_q && txb_q == $past(txb_q);
   endproperty
   a_wcol: assert property (p_wcol) else $error("busy write not refused");
   property p_rov;
      @(posedge clk) disable iff (!rst_n) (rx_done && rbf_q && !rd_rx) |=> rov_q && rbf_q;
   endproperty
   a_rov: assert property (p_rov) else $error("overflow not flagged");
   property p_da;
      @(posedge clk) disable iff (!rst_n) addr_match |=> !da_q;
   endproperty
   a_da: assert property (p_da) else $error("address match did not clear flag");
   property p_zero;
      @(posedge clk) disable iff (!rst_n) rd_q && $past(avs_address) == `TWS_OFF_STATUS |->
         avs_readdata[31:16] == 16'h0000 && avs_readdata[13:11] == 3'h0;
   endproperty
   a_zero: assert property (p_zero) else $error("reserved status bits not zero");
   c_tx: cover property (@(posedge clk) disable iff (!rst_n)
      st_q == tws_pkg::TWS_TX_ACK ##1 st_q == tws_pkg::TWS_TX_IDLE);
   c_ov: cover property (@(posedge clk) disable iff (!rst_n) rov_set);
   c_wc: cover property (@(posedge clk) disable iff (!rst_n) wcol_set);
endmodule

// >>> pkg/tws_consts.svh
// Offsets, field positions, the status mask and the general call address for the two-wire status flag block.
// Assumes inclusion by bare name from any file that needs them.
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH
`define TWS_OFF_STATUS 4'h0
`define TWS_OFF_CONTROL 4'h4
`define TWS_OFF_TXDATA 4'h8
`define TWS_OFF_RXDATA 4'hC
`define TWS_BIT_NACK 15
`define TWS_BIT_TXACT 14
`define TWS_BIT_BCOL 10
`define TWS_BIT_GCALL 9
`define TWS_BIT_TEN 8
`define TWS_BIT_WCOL 7
`define TWS_BIT_ROV 6
`define TWS_BIT_DA 5
`define TWS_BIT_STOP 4
`define TWS_BIT_START 3
`define TWS_BIT_RDIR 2
`define TWS_BIT_RBF 1
`define TWS_BIT_TBF 0
`define TWS_BIT_ENABLE 0
`define TWS_STATUS_MASK 32'h0000C7FF
`define TWS_GCALL_ADDR 8'h00
`endif

// >>> pkg/tws_pkg.sv
// Types shared by the two-wire status flag block.
// Assumes nothing of its surroundings.
package tws_pkg;
   // Master transmit progress states.
   typedef enum logic [1:0] {
      TWS_TX_IDLE = 2'b00,
      TWS_TX_BITS = 2'b01,
      TWS_TX_ACK = 2'b10
   } tws_tx_state_t;
endpackage

// >>> rtl/tws_sticky.sv
// One sticky flag: hardware set, software or hardware clear, set wins.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
module tws_sticky (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic set_i,
   input wire logic clr_i,
   output logic flag_q
);
   logic flag_d; // Next flag value.

   // A set in the very cycle of a clear still lands, so no event is lost.
   always_comb begin
      flag_d = flag_q;
      if (clr_i) begin
         flag_d = 1'b0;
      end
      if (set_i) begin
         flag_d = 1'b1;
      end
   end

   // Register the flag under synchronous reset.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end
endmodule

// >>> verif/tws_peer.sv
// Far-side model: bus peers and the shifter events they cause at the status block.
// Assumes the status block's clock; the testbench calls its tasks in sequence.
`timescale 1ns/1ps
module tws_peer (
   input wire logic clk,
   output logic [11:0] ev,
   output logic ack_nack,
   output logic [7:0] rx_byte,
   output logic read_dir
);
   // Everything idle at time zero.
   initial begin
      ev = 12'h000;
      ack_nack = 1'b0;
      rx_byte = 8'h00;
      read_dir = 1'b0;
   end
   // One pulse of one cycle; data lines then show the inverse, so no stale value passes for data.
   task automatic pulse(input int idx, input logic nack, input logic [7:0] b);
      @(posedge clk);
      ev <= 12'h001 << idx;
      ack_nack <= nack;
      rx_byte <= b;
      @(posedge clk);
      ev <= 12'h000;
      ack_nack <= ~nack;
      rx_byte <= ~b;
   endtask
   // Data bits of a master byte, one pulse per shifted bit.
   task automatic tx_bits(input int n);
      for (int i = 0; i < n; i++) begin
         pulse(1, 1'b0, 8'h00);
      end
   endtask
   // Direction is a level that the peer holds between frames.
   task automatic set_dir(input logic d);
      @(posedge clk);
      read_dir <= d;
   endtask
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the status block, with an integer model of the status word.
// Assumes the peer model drives every event input on the same clock.
`timescale 1ns/1ps
`include "tws_consts.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
   $display("[ERR] %0t got %h want %h", $time, a, b); end end
module testbench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [11:0] ev;
   logic ack_nack;
   logic [7:0] rx_byte;
   logic read_dir;
   logic [7:0] tx_data;
   logic module_on;
   logic [31:0] rd;
   logic [7:0] b0;
   int n_mismatch = 0;
   int n_compared = 0;
   int exp_st = 0; // Model of the status word.
   int rxq[$]; // Model of the receive buffer.
   always #12.5 clk = ~clk;
   tws_status tws_status_i (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .tx_start(ev[0]), .bit_done(ev[1]), .ack_end(ev[2]),
      .ack_nack(ack_nack), .collision(ev[3]), .addr_byte_rx(ev[4]), .addr_match(ev[5]),
      .ten_second_match(ev[6]), .slave_data_rx(ev[7]), .rx_done(ev[8]), .rx_byte(rx_byte),
      .start_seen(ev[9]), .stop_seen(ev[10]), .read_dir(read_dir), .tx_taken(ev[11]),
      .tx_data(tx_data), .module_on(module_on));
   tws_peer tws_peer_i (.clk(clk), .ev(ev), .ack_nack(ack_nack), .rx_byte(rx_byte), .read_dir(read_dir));
   // Prints the counts and the verdict, then stops.
   task automatic complete_run();
      $display("Counts: %0d compared, %0d mismatched", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // One Avalon transfer; the request stands until the edge that samples waitrequest low, where data is taken.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int i;
      q = 32'h0;
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0) begin
            q = avs_readdata;
            break;
         end
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // A transfer that never completes counts as a mismatch and ends the run.
      if (i == 20) begin
         n_mismatch++;
         complete_run();
      end
   endtask
   // Reads one word and compares it with the expected value.
   task automatic chk(input logic [3:0] a, input int e);
      bus(1'b0, a, 32'h0, rd);
      `CHK(rd, 32'(e))
   endtask
   // Peer event, model update, then a status read compared with the model.
   task automatic step(input int idx, input int set_m, input int clr_m, input logic nack, input logic [7:0] b);
      tws_peer_i.pulse(idx, nack, b);
      exp_st = (exp_st | set_m) & ~clr_m;
      chk(`TWS_OFF_STATUS, exp_st);
   endtask
   initial begin
      void'($urandom(16408));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      chk(`TWS_OFF_STATUS, 0);
      chk(4'h2, 0);
      bus(1'b1, `TWS_OFF_CONTROL, 32'h1, rd);
      chk(`TWS_OFF_CONTROL, 1);
      bus(1'b1, `TWS_OFF_STATUS, 32'hFFFFFFFF, rd);
      chk(`TWS_OFF_STATUS, 0);
      $display("test reset and map done");
      b0 = 8'($urandom);
      bus(1'b1, `TWS_OFF_TXDATA, {24'h0, b0}, rd);
      exp_st = 1;
      for (int k = 0; k < 2; k++) begin
         step(0, 1 << 14, 0, 1'b0, 8'h00);
         if (k == 0) begin
            bus(1'b1, `TWS_OFF_TXDATA, {24'h0, ~b0}, rd);
            @(negedge clk);
            `CHK(tx_data, b0)
            step(11, 1 << 7, 1, 1'b0, 8'h00);
         end
         tws_peer_i.tx_bits(8);
         chk(`TWS_OFF_STATUS, exp_st);
         step(2, (k == 0) << 15, (1 << 14) | ((k == 1) << 15), k == 0, 8'h00);
      end
      bus(1'b1, `TWS_OFF_STATUS, 32'hFFFFFF7F, rd);
      exp_st = 0;
      chk(`TWS_OFF_STATUS, exp_st);
      $display("test master transmit done");
      for (int k = 0; k < 3; k++) begin
         b0 = 8'($urandom);
         if (rxq.size() != 0) begin
            step(8, 1 << 6, 0, 1'b0, b0);
         end else begin
            rxq.push_back(b0);
            step(8, 2, 0, 1'b0, b0);
         end
      end
      chk(`TWS_OFF_RXDATA, rxq.pop_front());
      exp_st = 1 << 6;
      chk(`TWS_OFF_STATUS, exp_st);
      bus(1'b1, `TWS_OFF_STATUS, 32'hFFFFFFBF, rd);
      step(4, 0, 1 << 6, 1'b0, 8'($urandom) | 8'h01);
      $display("test receive overflow done");
      step(4, 1 << 9, 0, 1'b0, `TWS_GCALL_ADDR);
      step(7, 1 << 5, 0, 1'b0, 8'h00);
      step(5, 0, 1 << 5, 1'b0, 8'h00);
      step(6, 1 << 8, 0, 1'b0, 8'h00);
      step(9, 1 << 3, 1 << 4, 1'b0, 8'h00);
      tws_peer_i.set_dir(1'b1);
      exp_st = exp_st | 4;
      chk(`TWS_OFF_STATUS, exp_st);
      tws_peer_i.set_dir(1'b0);
      step(10, 1 << 4, (1 << 9) | (1 << 8) | (1 << 3) | 4, 1'b0, 8'h00);
      $display("test slave flags done");
      step(3, 1 << 10, 0, 1'b0, 8'h00);
      bus(1'b1, `TWS_OFF_STATUS, 32'h0, rd);
      bus(1'b1, `TWS_OFF_CONTROL, 32'h0, rd);
      @(negedge clk);
      `CHK(module_on, 1'b0)
      chk(`TWS_OFF_STATUS, exp_st);
      bus(1'b1, `TWS_OFF_CONTROL, 32'h1, rd);
      @(negedge clk);
      `CHK(module_on, 1'b1)
      exp_st = exp_st & ~(1 << 10);
      chk(`TWS_OFF_STATUS, exp_st);
      $display("test collision done");
      // A second reset in mid-run must bring every flag and the enable back to zero.
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      exp_st = 0;
      chk(`TWS_OFF_STATUS, exp_st);
      `CHK(module_on, 1'b0)
      $display("test reset in mid-run done");
      complete_run();
   end
endmodule
